// *** include/serial_port_pkg.sv ***
// Shared constants for the framed synchronous serial port pair.
// Assumes a 14-bit data-memory word address and 16-bit data words.
package serial_port_pkg;
  localparam int DATA_WIDTH = 16;
  localparam int ADDR_WIDTH = 14;
  localparam int LEN_WIDTH = 5;
  localparam int BUFFER_DEPTH = 2;

  // Memory-mapped configuration register addresses
  localparam logic [13:0] ADDR_PORT1_RX_FRAME_DIVIDER = 14'h3ff0;
  localparam logic [13:0] ADDR_PORT1_BIT_CLOCK_DIVIDER = 14'h3ff1;
  localparam logic [13:0] ADDR_PORT1_CONTROL = 14'h3ff2;
  localparam logic [13:0] ADDR_PORT0_RX_FRAME_DIVIDER = 14'h3ff4;
  localparam logic [13:0] ADDR_PORT0_BIT_CLOCK_DIVIDER = 14'h3ff5;
  localparam logic [13:0] ADDR_PORT0_CONTROL = 14'h3ff6;
  localparam logic [13:0] ADDR_SYSTEM_CONTROL = 14'h3fff;

  // System control fields
  localparam int SYS_PORT0_ENABLE_BIT = 12;
  localparam int SYS_PORT1_ENABLE_BIT = 11;
  localparam int SYS_PORT1_SERIAL_BIT = 10;
  localparam logic [15:0] SYSTEM_CONTROL_RESET = 16'h0400;

  // Port control fields
  localparam int CTL_INTERNAL_CLOCK_SELECT_BIT = 14;
  localparam int CTL_RX_SYNC_REQUIRED_BIT = 13;
  localparam int CTL_TX_SYNC_REQUIRED_BIT = 11;
  localparam int CTL_INTERNAL_TX_SYNC_BIT = 9;
  localparam int CTL_INTERNAL_RX_SYNC_BIT = 8;
  localparam int CTL_WORD_LENGTH_MSB = 3;
  localparam int CTL_WORD_LENGTH_LSB = 0;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;
endpackage : serial_port_pkg

// *** rtl/sync_serial_port_framing.sv ***
// Two synchronous serial ports with framing, clock generation and register file.
// Assumes all pins are asynchronous to sys_clk and sys_clk is much faster than any bit clock.
`timescale 1ns/1ps

// Behaviour
// - System control bit 12 enables port 0, bit 11 port 1; both clear at reset.
// - Bit 10 one makes port 1 serial; zero gives interrupt and flag pins, ignores enable.
// - Port 1 pin-function bit resets to one, serial configuration.
// - Control bit 14 one drives bit clock internally, zero takes it from the pin.
// - Internal clock select clears at reset; ports expect external bit clock.
// - Internal clock starts the cycle after the select is set, enabled or not.
// - Internal bit clock is system clock over two times divider plus one.
// - A new clock divider takes effect from the next bit clock rising edge.
// - Alternate configuration ignores external port 1 clock but still drives internal one.
// - Word length is the four-bit field plus one; software avoids zero and one.
// - Short words are right-justified in transmit and receive data registers.
// - All frame syncs are sampled on the bit clock falling edge.
// - Sync-required bit demands a sync per word; clear means one sync, then continuous.
// - Both sync-required bits clear at reset, so transfers need one sync, then run unframed.
// - Internal sync bits generate the sync and drive its pin, except port 1 in alternate configuration; otherwise the pin inputs.
// - Both internal sync source bits clear at reset; syncs come from outside.
// - With external syncs, transmit and receive wait for their sync before starting.
// - Internal transmit sync only when data waits, driven from the rise that starts the current last bit.
// - Internal receive sync repeats every receive divider plus one bit clocks.
// - Internal syncs work with an external bit clock, dividing it down.
// - Data registers are usable any time; a transmit write readies the port to send.
// - Transmit shifts MSB first, changing the data line on bit clock rising edges.
// - Transmit interrupt when a word's first bit leaves, freeing the register.
// - Each complete received word goes to the receive register with an interrupt.
// - Received bits are latched on the bit clock falling edge.
module sync_serial_port_framing (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Data-memory access to configuration registers
  input wire logic [serial_port_pkg::ADDR_WIDTH-1:0] dm_addr,
  input wire logic [serial_port_pkg::DATA_WIDTH-1:0] dm_wdata,
  input wire logic dm_write,
  input wire logic dm_read,
  output logic [serial_port_pkg::DATA_WIDTH-1:0] dm_rdata,
  // Transmit data registers, one valid/ready pair per port
  input wire logic [serial_port_pkg::DATA_WIDTH-1:0] port0_transmit_data,
  input wire logic [serial_port_pkg::DATA_WIDTH-1:0] port1_transmit_data,
  input wire logic [1:0] tx_valid,
  output logic [1:0] tx_ready,
  // Receive data registers and events
  output logic [serial_port_pkg::DATA_WIDTH-1:0] port0_receive_data,
  output logic [serial_port_pkg::DATA_WIDTH-1:0] port1_receive_data,
  output logic [1:0] tx_interrupt,
  output logic [1:0] rx_interrupt,
  // Serial pins, index is the port number
  input wire logic [1:0] bit_clock_in,
  output logic [1:0] bit_clock_out,
  output logic [1:0] bit_clock_oe_n,
  input wire logic [1:0] receive_frame_sync_in,
  output logic [1:0] receive_frame_sync_out,
  output logic [1:0] receive_frame_sync_oe_n,
  input wire logic [1:0] transmit_frame_sync_in,
  output logic [1:0] transmit_frame_sync_out,
  output logic [1:0] transmit_frame_sync_oe_n,
  input wire logic [1:0] serial_data_in,
  output logic [1:0] serial_data_out,
  output logic [1:0] serial_data_oe_n,
  // Port 1 alternate pin functions
  output logic external_interrupt_zero,
  output logic external_interrupt_one,
  output logic flag_input
);
  import serial_port_pkg::*;

  logic [15:0] sys_ctl_q;
  logic [15:0] ctl_q [2];
  logic [15:0] clk_div_q [2];
  logic [15:0] frame_div_q [2];
  logic [15:0] rx_word_q [2];
  logic [1:0] port_active;
  logic alt_pins;
  logic [1:0] clk_sy [2];
  logic [1:0] rfs_sy [2];
  logic [1:0] tfs_sy [2];
  logic [1:0] dr_sy [2];

  assign alt_pins = ~sys_ctl_q[SYS_PORT1_SERIAL_BIT];
  assign port_active[0] = sys_ctl_q[SYS_PORT0_ENABLE_BIT];
  assign port_active[1] = sys_ctl_q[SYS_PORT1_ENABLE_BIT] & ~alt_pins;
  assign port0_receive_data = rx_word_q[0];
  assign port1_receive_data = rx_word_q[1];

  // Configuration register writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_ctl_q <= SYSTEM_CONTROL_RESET;
      for (int i = 0; i < 2; i++) begin
        ctl_q[i] <= CONTROL_RESET;
        clk_div_q[i] <= DIVIDER_RESET;
        frame_div_q[i] <= DIVIDER_RESET;
      end
    end else if (dm_write) begin
      unique case (dm_addr)
        ADDR_PORT1_RX_FRAME_DIVIDER: frame_div_q[1] <= dm_wdata;
        ADDR_PORT1_BIT_CLOCK_DIVIDER: clk_div_q[1] <= dm_wdata;
        ADDR_PORT1_CONTROL: ctl_q[1] <= dm_wdata;
        ADDR_PORT0_RX_FRAME_DIVIDER: frame_div_q[0] <= dm_wdata;
        ADDR_PORT0_BIT_CLOCK_DIVIDER: clk_div_q[0] <= dm_wdata;
        ADDR_PORT0_CONTROL: ctl_q[0] <= dm_wdata;
        ADDR_SYSTEM_CONTROL: sys_ctl_q <= dm_wdata;
        default: ;
      endcase
    end
  end

  // Registered read; unmapped addresses return zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dm_rdata <= '0;
    end else if (dm_read) begin
      unique case (dm_addr)
        ADDR_PORT1_RX_FRAME_DIVIDER: dm_rdata <= frame_div_q[1];
        ADDR_PORT1_BIT_CLOCK_DIVIDER: dm_rdata <= clk_div_q[1];
        ADDR_PORT1_CONTROL: dm_rdata <= ctl_q[1];
        ADDR_PORT0_RX_FRAME_DIVIDER: dm_rdata <= frame_div_q[0];
        ADDR_PORT0_BIT_CLOCK_DIVIDER: dm_rdata <= clk_div_q[0];
        ADDR_PORT0_CONTROL: dm_rdata <= ctl_q[0];
        ADDR_SYSTEM_CONTROL: dm_rdata <= sys_ctl_q;
        default: dm_rdata <= '0;
      endcase
    end
  end

  // Port 1 alternate inputs come off the same synchronisers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      external_interrupt_zero <= 1'b0;
      external_interrupt_one <= 1'b0;
      flag_input <= 1'b0;
    end else begin
      external_interrupt_zero <= alt_pins & rfs_sy[1][1];
      external_interrupt_one <= alt_pins & tfs_sy[1][1];
      flag_input <= alt_pins & dr_sy[1][1];
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic internal_clock_select, internal_rx_sync, internal_tx_sync, rfs_req, tfs_req, alt;
    logic [4:0] len;
    logic [15:0] len_mask;
    logic [15:0] gen_cnt_q, gen_div_q;
    logic gen_clk_q, clk_now, clk_prev_q, rise, fall;
    logic rfs_seen, tfs_seen;
    logic [15:0] rfs_cnt_q;
    logic [4:0] rx_cnt_q;
    logic [15:0] rx_shift_q;
    logic rx_started_q, rx_start;
    logic [15:0] buf_q [BUFFER_DEPTH];
    logic buf_wr_q, buf_rd_q;
    logic [1:0] buf_cnt_q, buf_cnt_d;
    logic push, pop, avail_after;
    logic [4:0] tx_cnt_q, tx_cnt_d;
    logic [15:0] tx_shift_q;
    logic tx_go_q, tx_started_q;

    assign alt = (p == 1) && alt_pins;
    assign internal_clock_select = ctl_q[p][CTL_INTERNAL_CLOCK_SELECT_BIT];
    assign internal_rx_sync = ctl_q[p][CTL_INTERNAL_RX_SYNC_BIT];
    assign internal_tx_sync = ctl_q[p][CTL_INTERNAL_TX_SYNC_BIT];
    assign rfs_req = ctl_q[p][CTL_RX_SYNC_REQUIRED_BIT];
    assign tfs_req = ctl_q[p][CTL_TX_SYNC_REQUIRED_BIT];
    assign len = LEN_WIDTH'(ctl_q[p][CTL_WORD_LENGTH_MSB:CTL_WORD_LENGTH_LSB]) + 5'd1;
    assign len_mask = 16'hffff >> (5'd16 - len);

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        clk_sy[p] <= '0;
        rfs_sy[p] <= '0;
        tfs_sy[p] <= '0;
        dr_sy[p] <= '0;
      end else begin
        clk_sy[p] <= {clk_sy[p][0], bit_clock_in[p]};
        rfs_sy[p] <= {rfs_sy[p][0], receive_frame_sync_in[p]};
        tfs_sy[p] <= {tfs_sy[p][0], transmit_frame_sync_in[p]};
        dr_sy[p] <= {dr_sy[p][0], serial_data_in[p]};
      end
    end

    // Internal bit clock: half period of divider plus one system cycles
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        gen_cnt_q <= '0;
        gen_div_q <= DIVIDER_RESET;
        gen_clk_q <= 1'b0;
      end else if (!internal_clock_select) begin
        gen_cnt_q <= '0;
        gen_div_q <= clk_div_q[p];
        gen_clk_q <= 1'b0;
      end else if (gen_cnt_q == '0) begin
        gen_clk_q <= ~gen_clk_q;
        if (!gen_clk_q) begin
          gen_div_q <= clk_div_q[p];
          gen_cnt_q <= clk_div_q[p];
        end else begin
          gen_cnt_q <= gen_div_q;
        end
      end else begin
        gen_cnt_q <= gen_cnt_q - 16'h0001;
      end
    end
    assign bit_clock_out[p] = gen_clk_q;

    // External clock on the alternate pin reads as a stopped clock
    assign clk_now = internal_clock_select ? gen_clk_q : (alt ? 1'b0 : clk_sy[p][1]);
    assign rise = clk_now & ~clk_prev_q;
    assign fall = ~clk_now & clk_prev_q;
    assign rfs_seen = internal_rx_sync ? receive_frame_sync_out[p] : (~alt & rfs_sy[p][1]);
    assign tfs_seen = internal_tx_sync ? transmit_frame_sync_out[p] : (~alt & tfs_sy[p][1]);

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        clk_prev_q <= 1'b0;
        bit_clock_oe_n[p] <= 1'b1;
        receive_frame_sync_oe_n[p] <= 1'b1;
        transmit_frame_sync_oe_n[p] <= 1'b1;
        serial_data_oe_n[p] <= 1'b1;
      end else begin
        clk_prev_q <= clk_now;
        bit_clock_oe_n[p] <= ~internal_clock_select;
        receive_frame_sync_oe_n[p] <= ~(internal_rx_sync & ~alt);
        transmit_frame_sync_oe_n[p] <= ~(internal_tx_sync & ~alt);
        serial_data_oe_n[p] <= ~port_active[p];
      end
    end

    // Periodic receive sync, one bit clock wide
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        rfs_cnt_q <= '0;
        receive_frame_sync_out[p] <= 1'b0;
      end else if (!port_active[p] || !internal_rx_sync) begin
        rfs_cnt_q <= '0;
        receive_frame_sync_out[p] <= 1'b0;
      end else if (fall) begin
        if (rfs_cnt_q == '0) begin
          receive_frame_sync_out[p] <= 1'b1;
          rfs_cnt_q <= frame_div_q[p];
        end else begin
          receive_frame_sync_out[p] <= 1'b0;
          rfs_cnt_q <= rfs_cnt_q - 16'h0001;
        end
      end
    end

    // Receive: sync seen at a fall, bits taken from the following falls
    assign rx_start = (rx_cnt_q <= 5'd1) & (rfs_seen | (~rfs_req & rx_started_q));

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        rx_cnt_q <= '0;
        rx_shift_q <= '0;
        rx_started_q <= 1'b0;
        rx_word_q[p] <= '0;
        rx_interrupt[p] <= 1'b0;
      end else if (!port_active[p]) begin
        rx_cnt_q <= '0;
        rx_started_q <= 1'b0;
        rx_interrupt[p] <= 1'b0;
      end else begin
        rx_interrupt[p] <= 1'b0;
        if (fall) begin
          if (rx_cnt_q != '0) begin
            rx_shift_q <= {rx_shift_q[14:0], dr_sy[p][1]};
          end
          if (rx_cnt_q == 5'd1) begin
            rx_word_q[p] <= {rx_shift_q[14:0], dr_sy[p][1]} & len_mask;
            rx_interrupt[p] <= 1'b1;
          end
          if (rx_start) begin
            rx_cnt_q <= len;
            rx_started_q <= 1'b1;
          end else if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 5'd1;
          end
        end
      end
    end

    // Two-entry transmit buffer; full stalls the writer through tx_ready
    assign push = tx_valid[p] & tx_ready[p];
    assign pop = rise & tx_go_q;

    always_comb begin
      buf_cnt_d = buf_cnt_q;
      if (push && !pop) begin
        buf_cnt_d = buf_cnt_q + 2'd1;
      end else if (pop && !push) begin
        buf_cnt_d = buf_cnt_q - 2'd1;
      end
      avail_after = pop ? (buf_cnt_q == 2'd2) : (buf_cnt_q != 2'd0);
      tx_cnt_d = tx_cnt_q;
      if (pop) begin
        tx_cnt_d = len;
      end else if (rise && tx_cnt_q != '0) begin
        tx_cnt_d = tx_cnt_q - 5'd1;
      end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        buf_wr_q <= 1'b0;
        buf_rd_q <= 1'b0;
        buf_cnt_q <= '0;
        tx_ready[p] <= 1'b1;
        for (int i = 0; i < BUFFER_DEPTH; i++) begin
          buf_q[i] <= '0;
        end
      end else begin
        if (push) begin
          buf_q[buf_wr_q] <= (p == 0) ? port0_transmit_data : port1_transmit_data;
          buf_wr_q <= ~buf_wr_q;
        end
        if (pop) begin
          buf_rd_q <= ~buf_rd_q;
        end
        buf_cnt_q <= buf_cnt_d;
        tx_ready[p] <= buf_cnt_d != 2'd2;
      end
    end

    // Transmit: decision at a fall, first bit driven at the next rise
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        tx_cnt_q <= '0;
        tx_shift_q <= '0;
        tx_go_q <= 1'b0;
        tx_started_q <= 1'b0;
        tx_interrupt[p] <= 1'b0;
        transmit_frame_sync_out[p] <= 1'b0;
      end else if (!port_active[p]) begin
        tx_cnt_q <= '0;
        tx_go_q <= 1'b0;
        tx_started_q <= 1'b0;
        tx_interrupt[p] <= 1'b0;
        transmit_frame_sync_out[p] <= 1'b0;
      end else begin
        tx_interrupt[p] <= pop;
        tx_cnt_q <= tx_cnt_d;
        if (fall && !tx_go_q && tx_cnt_q <= 5'd1 && buf_cnt_q != 2'd0 &&
            (tfs_seen || (!tfs_req && tx_started_q))) begin
          tx_go_q <= 1'b1;
          tx_started_q <= 1'b1;
        end else if (pop) begin
          tx_go_q <= 1'b0;
        end
        if (pop) begin
          tx_shift_q <= buf_q[buf_rd_q] << (5'd16 - len);
        end else if (rise && tx_cnt_q > 5'd1) begin
          tx_shift_q <= {tx_shift_q[14:0], 1'b0};
        end
        if (rise) begin
          transmit_frame_sync_out[p] <= internal_tx_sync & avail_after & (tx_cnt_d <= 5'd1);
        end
      end
    end
    assign serial_data_out[p] = tx_shift_q[15];
  end
endmodule : sync_serial_port_framing

// *** testbench/sync_serial_port_framing_props.sv ***
// Concurrent checks on the serial port pair, seen from its top-level ports.
// Assumes one sys_clk domain with reset_n asynchronous and active low.
`timescale 1ns/1ps
module sync_serial_port_framing_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic [serial_port_pkg::ADDR_WIDTH-1:0] dm_addr,
  input wire logic [serial_port_pkg::DATA_WIDTH-1:0] dm_wdata,
  input wire logic dm_write,
  input wire logic dm_read,
  input wire logic [serial_port_pkg::DATA_WIDTH-1:0] dm_rdata,
  // Data and events
  input wire logic [1:0] tx_ready,
  input wire logic [1:0] tx_interrupt,
  input wire logic [1:0] rx_interrupt,
  input wire logic [serial_port_pkg::DATA_WIDTH-1:0] port0_receive_data,
  // Pins
  input wire logic [1:0] bit_clock_oe_n,
  input wire logic [1:0] receive_frame_sync_out,
  input wire logic [1:0] receive_frame_sync_oe_n,
  input wire logic [1:0] transmit_frame_sync_out,
  input wire logic [1:0] transmit_frame_sync_oe_n,
  input wire logic [1:0] serial_data_in,
  input wire logic [1:0] serial_data_oe_n,
  input wire logic flag_input
);
  import serial_port_pkg::*;
  wire logic mapped = dm_addr inside {ADDR_PORT1_RX_FRAME_DIVIDER, ADDR_PORT1_BIT_CLOCK_DIVIDER, ADDR_PORT1_CONTROL,
    ADDR_PORT0_RX_FRAME_DIVIDER, ADDR_PORT0_BIT_CLOCK_DIVIDER, ADDR_PORT0_CONTROL, ADDR_SYSTEM_CONTROL};
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  reset_outputs_a: assert property ($rose(reset_n) |-> tx_ready == 2'b11 && bit_clock_oe_n == 2'b11
    && receive_frame_sync_oe_n == 2'b11 && transmit_frame_sync_oe_n == 2'b11) else $error("pins not idle after reset");
  clock_source_a: assert property (dm_write && dm_addr == ADDR_PORT0_CONTROL |-> ##2
    bit_clock_oe_n[0] == !$past(dm_wdata[14], 2)) else $error("bit clock direction wrong");
  sync_source_a: assert property (dm_write && dm_addr == ADDR_PORT0_CONTROL |-> ##2
    receive_frame_sync_oe_n[0] == !$past(dm_wdata[8], 2) && transmit_frame_sync_oe_n[0] == !$past(dm_wdata[9], 2))
    else $error("frame sync direction wrong");
  port_enable_a: assert property (dm_write && dm_addr == ADDR_SYSTEM_CONTROL |-> ##2
    serial_data_oe_n[0] == !$past(dm_wdata[12], 2)) else $error("port enable not applied");
  reg_readback_a: assert property (dm_write && mapped ##2 dm_read && dm_addr == $past(dm_addr, 2) |=>
    dm_rdata == $past(dm_wdata, 3)) else $error("register read back differs");
  unmapped_read_a: assert property (dm_read && !mapped |=> dm_rdata == 16'h0000)
    else $error("unmapped read not zero");
  tx_pulse_a: assert property (tx_interrupt[0] |=> !tx_interrupt[0] [*4]) else $error("transmit event repeated");
  rx_update_a: assert property ($changed(port0_receive_data) |-> rx_interrupt[0])
    else $error("receive data changed without event");
  alt_flag_a: assert property (flag_input |-> $past(serial_data_in[1], 2) || $past(serial_data_in[1], 3)
    || $past(serial_data_in[1], 4)) else $error("flag input without pin level");
  disabled_idle_a: assert property (serial_data_oe_n[0] [*3] |-> !receive_frame_sync_out[0]
    && !transmit_frame_sync_out[0]) else $error("disabled port drives a sync");

  cover property (rx_interrupt[0]);
  cover property (tx_interrupt[0]);
  cover property (!bit_clock_oe_n[0] && serial_data_oe_n[0]);
endmodule : sync_serial_port_framing_props

bind sync_serial_port_framing sync_serial_port_framing_props i_props (.sys_clk, .reset_n, .dm_addr, .dm_wdata,
  .dm_write, .dm_read, .dm_rdata, .tx_ready, .tx_interrupt, .rx_interrupt, .port0_receive_data, .bit_clock_oe_n,
  .receive_frame_sync_out, .receive_frame_sync_oe_n, .transmit_frame_sync_out, .transmit_frame_sync_oe_n,
  .serial_data_in, .serial_data_oe_n, .flag_input);

// *** testbench/codec_model.sv ***
// Behavioural codec on the far side of serial port 0.
// Assumes the port takes an external bit clock and one active-high sync for both directions.
`timescale 1ns/1ps
module codec_model #(
  parameter int HALF_NS = 64
) (
  // Serial pins seen from the codec
  output logic bit_clock,
  output logic frame_sync,
  output logic data_to_port,
  input wire logic data_from_port
);
  initial begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    data_to_port = 1'b0;
  end

  // One framed word each way; the clock stands still between frames
  task automatic frame(input logic [15:0] word, input int len, output logic [15:0] heard);
    int i;
    heard = 16'h0000;
    #3 frame_sync = 1'b1;
    #HALF_NS bit_clock = 1'b1;
    #HALF_NS bit_clock = 1'b0;
    // Held past the fall so the synchroniser sees it
    #(HALF_NS / 2) frame_sync = 1'b0;
    #(HALF_NS / 2);
    for (i = len - 1; i >= 0; i--) begin
      bit_clock = 1'b1;
      data_to_port = word[i];
      #HALF_NS bit_clock = 1'b0;
      heard = {heard[14:0], data_from_port};
      #HALF_NS;
    end
    // Released line must not look like a held bit
    data_to_port = ~data_to_port;
  endtask : frame
endmodule : codec_model

// *** testbench/sync_serial_port_framing_bench.sv ***
// Self-checking bench for the serial port pair with a codec model on port 0.
// Assumes the checker binds itself to the design; port 1 pins are driven here.
`timescale 1ns/1ps
module sync_serial_port_framing_bench;
  import serial_port_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_WIDTH-1:0] dm_addr = '0;
  logic [DATA_WIDTH-1:0] dm_wdata = '0;
  logic dm_write = 1'b0;
  logic dm_read = 1'b0;
  logic [DATA_WIDTH-1:0] tx_word = '0;
  logic [1:0] tx_valid = 2'b00;
  logic [2:0] port1_pins = 3'b000; // Data, transmit sync, receive sync
  logic port1_clock = 1'b0;
  int miscompares = 0;
  int comparisons = 0;
  int tx_events = 0;
  int rx_events = 0;
  wire logic [DATA_WIDTH-1:0] dm_rdata, rx_word0, rx_word1;
  wire logic [1:0] tx_ready, tx_interrupt, rx_interrupt, clk_out, clk_oe_n, rfs_out, rfs_oe_n;
  wire logic [1:0] tfs_out, tfs_oe_n, data_out, data_oe_n;
  wire logic ext_int0, ext_int1, flag_in, codec_clock, codec_sync, codec_data;
  wire logic [1:0] clk_pin = {port1_clock, clk_oe_n[0] ? codec_clock : clk_out[0]};
  wire logic rfs_pin = rfs_oe_n[0] ? codec_sync : rfs_out[0];
  wire logic tfs_pin = tfs_oe_n[0] ? codec_sync : tfs_out[0];

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (tx_interrupt[0] === 1'b1) tx_events++;
    if (rx_interrupt[0] === 1'b1) rx_events++;
  end

  sync_serial_port_framing i_dut (.sys_clk, .reset_n, .dm_addr, .dm_wdata, .dm_write, .dm_read, .dm_rdata,
    .port0_transmit_data(tx_word), .port1_transmit_data(16'h0000), .tx_valid, .tx_ready,
    .port0_receive_data(rx_word0), .port1_receive_data(rx_word1), .tx_interrupt, .rx_interrupt,
    .bit_clock_in(clk_pin), .bit_clock_out(clk_out), .bit_clock_oe_n(clk_oe_n),
    .receive_frame_sync_in({port1_pins[0], rfs_pin}), .receive_frame_sync_out(rfs_out),
    .receive_frame_sync_oe_n(rfs_oe_n), .transmit_frame_sync_in({port1_pins[1], tfs_pin}),
    .transmit_frame_sync_out(tfs_out), .transmit_frame_sync_oe_n(tfs_oe_n),
    .serial_data_in({port1_pins[2], codec_data}), .serial_data_out(data_out), .serial_data_oe_n(data_oe_n),
    .external_interrupt_zero(ext_int0), .external_interrupt_one(ext_int1), .flag_input(flag_in));
  codec_model i_codec (.bit_clock(codec_clock), .frame_sync(codec_sync), .data_to_port(codec_data),
    .data_from_port(data_out[0]));

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_WIDTH-1:0] addr, input logic [DATA_WIDTH-1:0] data);
    @(posedge sys_clk);
    dm_addr <= addr;
    dm_wdata <= data;
    dm_write <= 1'b1;
    @(posedge sys_clk);
    dm_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_WIDTH-1:0] addr, input logic [DATA_WIDTH-1:0] exp);
    @(posedge sys_clk);
    dm_addr <= addr;
    dm_read <= 1'b1;
    @(posedge sys_clk);
    dm_read <= 1'b0;
    #1 check(dm_rdata, exp);
  endtask : rd

  task automatic push(input logic [DATA_WIDTH-1:0] data);
    int n;
    @(posedge sys_clk);
    tx_word <= data;
    tx_valid[0] <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (tx_ready[0] === 1'b1) break;
    end
    tx_valid[0] <= 1'b0;
    if (n == 50) begin
      miscompares++;
      complete_run();
    end
  endtask : push

  // Cycles from one toggle of the internal clock to the next
  task automatic half_period(output int cyc);
    logic level;
    int n;
    @(posedge sys_clk);
    #1 level = clk_out[0];
    for (n = 0; n < 64 && clk_out[0] === level; n++) begin
      @(posedge sys_clk);
      #1;
    end
    level = clk_out[0];
    for (cyc = 0; cyc < 64 && clk_out[0] === level; cyc++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 64 || cyc == 64) begin
      miscompares++;
      complete_run();
    end
  endtask : half_period

  task automatic test_reset_values();
    check(tx_ready, 2'b11);
    check({clk_oe_n, rfs_oe_n, tfs_oe_n}, 6'h3f);
    rd(ADDR_SYSTEM_CONTROL, 16'h0400);
    rd(ADDR_PORT0_CONTROL, 16'h0000);
    rd(ADDR_PORT1_CONTROL, 16'h0000);
    $display("reset values test done");
  endtask : test_reset_values

  task automatic test_registers();
    logic [ADDR_WIDTH-1:0] regs [6] = '{ADDR_PORT0_RX_FRAME_DIVIDER, ADDR_PORT0_BIT_CLOCK_DIVIDER,
      ADDR_PORT0_CONTROL, ADDR_PORT1_RX_FRAME_DIVIDER, ADDR_PORT1_BIT_CLOCK_DIVIDER, ADDR_PORT1_CONTROL};
    logic [DATA_WIDTH-1:0] value;
    for (int i = 0; i < 6; i++) begin
      value = (i % 3 == 2) ? 16'h6b0f : 16'ha5c3 ^ 16'(i);
      wr(regs[i], value);
      rd(regs[i], value);
    end
    wr(14'h3ff3, 16'hffff);
    rd(14'h3ff3, 16'h0000);
    $display("register test done");
  endtask : test_registers

  task automatic test_internal_clock();
    int cyc;
    wr(ADDR_PORT0_CONTROL, 16'h0007); // Stops the generator left running with a huge divider
    wr(ADDR_PORT0_BIT_CLOCK_DIVIDER, 16'h0002);
    wr(ADDR_PORT0_CONTROL, 16'h4007); // Port still disabled
    half_period(cyc);
    check(16'(cyc), 16'h0003);
    check(clk_oe_n[0], 1'b0);
    wr(ADDR_PORT0_BIT_CLOCK_DIVIDER, 16'h0000);
    half_period(cyc);
    half_period(cyc);
    check(16'(cyc), 16'h0001);
    $display("internal clock test done");
  endtask : test_internal_clock

  task automatic test_transfer();
    logic [15:0] heard;
    wr(ADDR_PORT0_CONTROL, 16'h2807);
    push(16'h00a5);
    push(16'h005a);
    #1 check(tx_ready[0], 1'b0);
    check(16'(tx_events), 16'h0000);
    wr(ADDR_SYSTEM_CONTROL, 16'h1400);
    i_codec.frame(16'h00c3, 8, heard);
    check(heard, 16'h00a5);
    check(rx_word0, 16'h00c3);
    i_codec.frame(16'h013c, 8, heard);
    check(heard, 16'h005a);
    check(rx_word0, 16'h003c);
    check(16'(tx_events * 256 + rx_events), 16'h0202);
    check(tx_ready[0], 1'b1);
    $display("transfer test done");
  endtask : test_transfer

  // Internal receive sync on port 0, fastest internal bit clock
  task automatic test_rx_sync();
    int n;
    int cyc;
    wr(ADDR_PORT0_RX_FRAME_DIVIDER, 16'h0007); // Period no shorter than the word
    wr(ADDR_PORT0_CONTROL, 16'h4107);
    for (n = 0; n < 64 && rfs_out[0] !== 1'b1; n++) @(posedge sys_clk);
    for (n = 0; n < 64 && rfs_out[0] === 1'b1; n++) @(posedge sys_clk);
    for (cyc = 0; cyc < 64 && rfs_out[0] !== 1'b1; cyc++) @(posedge sys_clk);
    if (cyc == 64) begin
      miscompares++;
      complete_run();
    end
    check(16'(cyc + n), 16'h0010);
    check(rfs_oe_n[0], 1'b0);
    $display("receive sync test done");
  endtask : test_rx_sync

  task automatic test_alternate();
    logic level;
    wr(ADDR_SYSTEM_CONTROL, 16'h1800); // Port 1 enable set, pins alternate
    wr(ADDR_PORT1_BIT_CLOCK_DIVIDER, 16'h0000);
    wr(ADDR_PORT1_CONTROL, 16'h0000); // Restart the generator with the new divider
    wr(ADDR_PORT1_CONTROL, 16'h4000);
    @(posedge sys_clk);
    port1_pins <= 3'b101;
    port1_clock <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 check({flag_in, ext_int1, ext_int0}, 3'b101);
    check(clk_oe_n[1], 1'b0);
    level = clk_out[1];
    @(posedge sys_clk);
    #1 check(clk_out[1] ^ level, 1'b1);
    @(posedge sys_clk);
    port1_pins <= 3'b010;
    repeat (4) @(posedge sys_clk);
    #1 check({flag_in, ext_int1, ext_int0}, 3'b010);
    $display("alternate pins test done");
  endtask : test_alternate

  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    test_reset_values();
    test_registers();
    test_internal_clock();
    test_transfer();
    test_rx_sync();
    test_alternate();
    complete_run();
  end
endmodule : sync_serial_port_framing_bench
